// [design/i2rt_regs.vh]
// Constants for the I2C rate, hold timing and own-address block
// Notes on behaviour
// RULE_01 - Clock and data lines driven and sensed
// RULE_02 - Own address held in station bits 7..1
// RULE_03 - Own address: full 7-bit, or low 10-bit part
// RULE_04 - Scale select: 00 x1, 01 x2, 10 x4
// RULE_05 - Rate code selects divider and three holds
// RULE_06 - Bit rate is clock over scale times divider
// RULE_07 - Data changes scaled hold after clock falls
// RULE_08 - Start: data low, scaled hold, clock low
// RULE_09 - Stop: clock high, scaled hold, data rises
// RULE_10 - Fixed table maps code to four counts
// RULE_11 - Table continues for codes 20..3f
`ifndef I2RT_REGS_VH
`define I2RT_REGS_VH

// ----------------------------------------------------------------------------
// Register selects and fields
// ----------------------------------------------------------------------------
`define I2RT_SEL_STATION   1'b0
`define I2RT_SEL_RATE      1'b1
`define I2RT_STATION_RST   8'h00
`define I2RT_RATE_RST      8'h00
`define I2RT_ADDR_HI       7
`define I2RT_ADDR_LO       1
`define I2RT_SCALE_HI      7
`define I2RT_SCALE_LO      6
`define I2RT_CODE_HI       5
`define I2RT_CODE_LO       0
`define I2RT_SCALE_X1      2'h0
`define I2RT_SCALE_X2      2'h1
`define I2RT_SCALE_X4      2'h2

// ----------------------------------------------------------------------------
// Counter width and count constants
// ----------------------------------------------------------------------------
`define I2RT_CW            14
`define I2RT_CNT_ONE       14'h0001
`define I2RT_CNT_ZERO      14'h0000

`endif

// [design/i2rt_timing.v]
// I2C master line sequencer with rate table, hold timing and own address
`timescale 1ns/1ns
`include "i2rt_regs.vh"
module i2rt_timing (
    ref_clk,
    rst_b,
    reg_wr,
    reg_sel,
    reg_wdata,
    reg_rdata,
    start_req,
    stop_req,
    bit_req,
    bit_val,
    busy,
    done,
    rx_bit,
    addr_in,
    addr_match,
    scl_in,
    scl_out,
    scl_oe,
    sda_in,
    sda_out,
    sda_oe
);
    input  wire        ref_clk;
    input  wire        rst_b;
    input  wire        reg_wr;
    input  wire        reg_sel;
    input  wire [7:0]  reg_wdata;
    output reg  [7:0]  reg_rdata;
    input  wire        start_req;
    input  wire        stop_req;
    input  wire        bit_req;
    input  wire        bit_val;
    output wire        busy;
    output reg         done;
    output reg         rx_bit;
    input  wire [6:0]  addr_in;
    output wire        addr_match;
    input  wire        scl_in;
    output wire        scl_out;
    output wire        scl_oe;
    input  wire        sda_in;
    output wire        sda_out;
    output wire        sda_oe;
    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_STA  = 4'h1;
    localparam [3:0] S_HELD = 4'h2;
    localparam [3:0] S_SDAH = 4'h3;
    localparam [3:0] S_LOW  = 4'h4;
    localparam [3:0] S_HIGH = 4'h5;
    localparam [3:0] S_SPL  = 4'h6;
    localparam [3:0] S_SPH  = 4'h7;
    localparam [3:0] S_RSU  = 4'h8;
    reg  [1:0]            rst_sync_r;
    wire                  rst_n;
    reg  [7:0]            station_id_r;
    reg  [7:0]            bit_rate_r;
    reg  [3:0]            state_r;
    reg  [`I2RT_CW-1:0]   cnt_r;
    reg                   scl_low_r;
    reg                   sda_low_r;
    reg                   tx_bit_r;
    reg  [1:0]            shamt;
    reg  [43:0]           lut;
    wire [`I2RT_CW-1:0]   div_s;
    wire [`I2RT_CW-1:0]   sdah_s;
    wire [`I2RT_CW-1:0]   sta_s;
    wire [`I2RT_CW-1:0]   sto_s;
    wire [`I2RT_CW-1:0]   half_s;
    wire [`I2RT_CW-1:0]   low_s;
    wire                  cnt_end;
    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];
    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            station_id_r <= `I2RT_STATION_RST;
            bit_rate_r   <= `I2RT_RATE_RST;
        end else if (reg_wr) begin
            if (reg_sel == `I2RT_SEL_STATION)
                station_id_r <= {reg_wdata[`I2RT_ADDR_HI:`I2RT_ADDR_LO], 1'b0}; // RULE_02
            else
                bit_rate_r <= reg_wdata;
        end
    end

    always @* begin
        if (reg_sel == `I2RT_SEL_STATION)
            reg_rdata = station_id_r;
        else
            reg_rdata = bit_rate_r;
    end

    // Same compare serves 7-bit addresses and the low part of 10-bit ones
    assign addr_match = (addr_in == station_id_r[`I2RT_ADDR_HI:`I2RT_ADDR_LO]); // RULE_02 RULE_03
    // ------------------------------------------------------------------------
    // Scale decode and rate table: {divider, data hold, start hold, stop hold}
    // ------------------------------------------------------------------------
    always @* begin
        case (bit_rate_r[`I2RT_SCALE_HI:`I2RT_SCALE_LO]) // RULE_04
            `I2RT_SCALE_X1: shamt = 2'h0;
            `I2RT_SCALE_X2: shamt = 2'h1;
            `I2RT_SCALE_X4: shamt = 2'h2;
            default:        shamt = 2'h0;
        endcase
    end

    always @* begin
        case (bit_rate_r[`I2RT_CODE_HI:`I2RT_CODE_LO]) // RULE_05 RULE_10
            6'h00: lut = {12'd20, 10'd7, 11'd6, 11'd11};
            6'h01: lut = {12'd22, 10'd7, 11'd7, 11'd12};
            6'h02: lut = {12'd24, 10'd8, 11'd8, 11'd13};
            6'h03: lut = {12'd26, 10'd8, 11'd9, 11'd14};
            6'h04: lut = {12'd28, 10'd9, 11'd10, 11'd15};
            6'h05: lut = {12'd30, 10'd9, 11'd11, 11'd16};
            6'h06: lut = {12'd34, 10'd10, 11'd13, 11'd18};
            6'h07: lut = {12'd40, 10'd10, 11'd16, 11'd21};
            6'h08: lut = {12'd28, 10'd7, 11'd10, 11'd15};
            6'h09: lut = {12'd32, 10'd7, 11'd12, 11'd17};
            6'h0a: lut = {12'd36, 10'd9, 11'd14, 11'd19};
            6'h0b: lut = {12'd40, 10'd9, 11'd16, 11'd21};
            6'h0c: lut = {12'd44, 10'd11, 11'd18, 11'd23};
            6'h0d: lut = {12'd48, 10'd11, 11'd20, 11'd25};
            6'h0e: lut = {12'd56, 10'd13, 11'd24, 11'd29};
            6'h0f: lut = {12'd68, 10'd13, 11'd30, 11'd35};
            6'h10: lut = {12'd48, 10'd9, 11'd18, 11'd25};
            6'h11: lut = {12'd56, 10'd9, 11'd22, 11'd29};
            6'h12: lut = {12'd64, 10'd13, 11'd26, 11'd33};
            6'h13: lut = {12'd72, 10'd13, 11'd30, 11'd37};
            6'h14: lut = {12'd80, 10'd17, 11'd34, 11'd41};
            6'h15: lut = {12'd88, 10'd17, 11'd38, 11'd45};
            6'h16: lut = {12'd104, 10'd21, 11'd46, 11'd53};
            6'h17: lut = {12'd128, 10'd21, 11'd58, 11'd65};
            6'h18: lut = {12'd80, 10'd9, 11'd38, 11'd41};
            6'h19: lut = {12'd96, 10'd9, 11'd46, 11'd49};
            6'h1a: lut = {12'd112, 10'd17, 11'd54, 11'd57};
            6'h1b: lut = {12'd128, 10'd17, 11'd62, 11'd65};
            6'h1c: lut = {12'd144, 10'd25, 11'd70, 11'd73};
            6'h1d: lut = {12'd160, 10'd25, 11'd78, 11'd81};
            6'h1e: lut = {12'd192, 10'd33, 11'd94, 11'd97};
            6'h1f: lut = {12'd240, 10'd33, 11'd118, 11'd121};
            6'h20: lut = {12'd160, 10'd17, 11'd78, 11'd81}; // RULE_11
            6'h21: lut = {12'd192, 10'd17, 11'd94, 11'd97};
            6'h22: lut = {12'd224, 10'd33, 11'd110, 11'd113};
            6'h23: lut = {12'd256, 10'd33, 11'd126, 11'd129};
            6'h24: lut = {12'd288, 10'd49, 11'd142, 11'd145};
            6'h25: lut = {12'd320, 10'd49, 11'd158, 11'd161};
            6'h26: lut = {12'd384, 10'd65, 11'd190, 11'd193};
            6'h27: lut = {12'd480, 10'd65, 11'd238, 11'd241};
            6'h28: lut = {12'd320, 10'd33, 11'd158, 11'd161};
            6'h29: lut = {12'd384, 10'd33, 11'd190, 11'd193};
            6'h2a: lut = {12'd448, 10'd65, 11'd222, 11'd225};
            6'h2b: lut = {12'd512, 10'd65, 11'd254, 11'd257};
            6'h2c: lut = {12'd576, 10'd97, 11'd286, 11'd289};
            6'h2d: lut = {12'd640, 10'd97, 11'd318, 11'd321};
            6'h2e: lut = {12'd768, 10'd129, 11'd382, 11'd385};
            6'h2f: lut = {12'd960, 10'd129, 11'd478, 11'd481};
            6'h30: lut = {12'd640, 10'd65, 11'd318, 11'd321};
            6'h31: lut = {12'd768, 10'd65, 11'd382, 11'd385};
            6'h32: lut = {12'd896, 10'd129, 11'd446, 11'd449};
            6'h33: lut = {12'd1024, 10'd129, 11'd510, 11'd513};
            6'h34: lut = {12'd1152, 10'd193, 11'd574, 11'd577};
            6'h35: lut = {12'd1280, 10'd193, 11'd638, 11'd641};
            6'h36: lut = {12'd1536, 10'd257, 11'd766, 11'd769};
            6'h37: lut = {12'd1920, 10'd257, 11'd958, 11'd961};
            6'h38: lut = {12'd1280, 10'd129, 11'd638, 11'd641};
            6'h39: lut = {12'd1536, 10'd129, 11'd766, 11'd769};
            6'h3a: lut = {12'd1792, 10'd257, 11'd894, 11'd897};
            6'h3b: lut = {12'd2048, 10'd257, 11'd1022, 11'd1025};
            6'h3c: lut = {12'd2304, 10'd385, 11'd1150, 11'd1153};
            6'h3d: lut = {12'd2560, 10'd385, 11'd1278, 11'd1281};
            6'h3e: lut = {12'd3072, 10'd513, 11'd1534, 11'd1537};
            default: lut = {12'd3840, 10'd513, 11'd1918, 11'd1921};
        endcase
    end

    // Scaled counts; the bit period is scale times divider, split into halves
    assign div_s  = {2'h0, lut[43:32]} << shamt;  // RULE_06
    assign sdah_s = {4'h0, lut[31:22]} << shamt;  // RULE_07
    assign sta_s  = {3'h0, lut[21:11]} << shamt;  // RULE_08
    assign sto_s  = {3'h0, lut[10:0]} << shamt;   // RULE_09
    assign half_s = div_s >> 1;
    assign low_s  = half_s - sdah_s;
    assign cnt_end = (cnt_r <= `I2RT_CNT_ONE);
    // ------------------------------------------------------------------------
    // Line sequencer
    // ------------------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= S_IDLE;
            cnt_r     <= `I2RT_CNT_ZERO;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
            tx_bit_r  <= 1'b0;
            done      <= 1'b0;
            rx_bit    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!cnt_end)
                cnt_r <= cnt_r - `I2RT_CNT_ONE;
            case (state_r)
                S_IDLE: if (start_req) begin
                    sda_low_r <= 1'b1;                     // RULE_08
                    cnt_r     <= sta_s;
                    state_r   <= S_STA;
                end
                S_STA: if (cnt_end) begin
                    scl_low_r <= 1'b1;                     // RULE_08
                    cnt_r     <= sdah_s;                   // RULE_07
                    done      <= 1'b1;
                    state_r   <= S_HELD;
                end
                S_HELD: begin
                    tx_bit_r <= bit_val;
                    if (bit_req)
                        state_r <= S_SDAH;
                    else if (stop_req)
                        state_r <= S_SPL;
                    else if (start_req)
                        state_r <= S_RSU;
                end
                S_SDAH: if (cnt_end) begin
                    sda_low_r <= ~tx_bit_r;                // RULE_07
                    cnt_r     <= low_s;
                    state_r   <= S_LOW;
                end
                S_LOW: if (cnt_end) begin
                    scl_low_r <= 1'b0;
                    cnt_r     <= half_s;
                    state_r   <= S_HIGH;
                end
                S_HIGH: begin
                    // High half counts only once the line is really high
                    if (!scl_in)
                        cnt_r <= half_s;                   // RULE_01
                    else if (cnt_end) begin
                        rx_bit    <= sda_in;               // RULE_01
                        scl_low_r <= 1'b1;
                        cnt_r     <= sdah_s;               // RULE_07
                        done      <= 1'b1;
                        state_r   <= S_HELD;
                    end
                end
                S_SPL: if (cnt_end) begin
                    sda_low_r <= 1'b1;
                    scl_low_r <= 1'b0;                     // RULE_09
                    cnt_r     <= sto_s;
                    state_r   <= S_SPH;
                end
                S_SPH: begin
                    if (!scl_in)
                        cnt_r <= sto_s;
                    else if (cnt_end) begin
                        sda_low_r <= 1'b0;                 // RULE_09
                        done      <= 1'b1;
                        state_r   <= S_IDLE;
                    end
                end
                S_RSU: if (cnt_end) begin
                    if (scl_low_r) begin
                        sda_low_r <= 1'b0;
                        scl_low_r <= 1'b0;
                        cnt_r     <= half_s;
                    end else if (scl_in) begin
                        sda_low_r <= 1'b1;                 // RULE_08
                        cnt_r     <= sta_s;
                        state_r   <= S_STA;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Open-drain: only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe  = scl_low_r;  // RULE_01
    assign sda_oe  = sda_low_r;  // RULE_01
    assign busy    = (state_r != S_IDLE) && (state_r != S_HELD);
endmodule // i2rt_timing

// [testbench/i2rt_checker.sv]
// Concurrent checks on the ports of the I2C rate and hold timing block
`timescale 1ns/1ns
module i2rt_checker (
    input wire       ref_clk,
    input wire       rst_b,
    input wire       reg_wr,
    input wire       reg_sel,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire [6:0] addr_in,
    input wire       addr_match,
    input wire       scl_out,
    input wire       scl_oe,
    input wire       sda_out,
    input wire       sda_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_start; $rose(sda_oe) && !scl_oe; endsequence
    sequence s_stop; $fell(sda_oe) && !scl_oe && !$past(scl_oe); endsequence
    property p_scl_od; scl_out == 1'b0; endproperty
    a_scl_od: assert property (p_scl_od) else $error("clock output not low");
    property p_sda_od; sda_out == 1'b0; endproperty
    a_sda_od: assert property (p_sda_od) else $error("data output not low");
    property p_station_wr; reg_wr && !reg_sel ##1 !reg_sel |-> reg_rdata == {$past(reg_wdata[7:1]), 1'b0}; endproperty
    a_station_wr: assert property (p_station_wr) else $error("station write lost");
    property p_rate_wr; reg_wr && reg_sel ##1 reg_sel |-> reg_rdata == $past(reg_wdata); endproperty
    a_rate_wr: assert property (p_rate_wr) else $error("rate write lost");
    property p_addr; !reg_sel |-> addr_match == (addr_in == reg_rdata[7:1]); endproperty
    a_addr: assert property (p_addr) else $error("address compare wrong");
    property p_start; s_start |=> !scl_oe [*4]; endproperty
    a_start: assert property (p_start) else $error("start hold too short");
    property p_stop; s_stop |-> !$past(scl_oe, 9); endproperty
    a_stop: assert property (p_stop) else $error("stop hold too short");
    property p_hold; $rose(scl_oe) |=> $stable(sda_oe) [*5]; endproperty
    a_hold: assert property (p_hold) else $error("data hold too short");
    property p_high; $fell(scl_oe) |=> !scl_oe [*8]; endproperty
    a_high: assert property (p_high) else $error("clock high too short");
endmodule // i2rt_checker

// [testbench/i2rt_bus_model.sv]
// Bus model: pull-ups, a stretching slave and a slave that pulls data low
`timescale 1ns/1ns
module i2rt_bus_model (
    input  wire       ref_clk,
    input  wire       scl_oe,
    input  wire       sda_oe,
    input  wire [3:0] stretch,
    input  wire       sda_pull,
    output wire       scl_line,
    output wire       sda_line
);
    reg [3:0] hold_r = 4'h0;
    reg       oe_d_r = 1'b0;
    always @(posedge ref_clk) begin
        oe_d_r <= scl_oe;
        if (oe_d_r && !scl_oe && stretch != 4'h0) hold_r <= stretch - 4'h1;
        else if (hold_r != 4'h0) hold_r <= hold_r - 4'h1;
    end
    // Wired-AND with pull-ups; clock held low for stretch cycles after each release
    assign scl_line = !(scl_oe || hold_r != 4'h0 || (oe_d_r && stretch != 4'h0));
    assign sda_line = !(sda_oe || sda_pull);
endmodule // i2rt_bus_model

// [testbench/i2rt_timing_tb.sv]
// Self-checking bench for the I2C rate and hold timing block
`timescale 1ns/1ns
module i2rt_timing_tb;
    reg        ref_clk = 1'b0, rst_b = 1'b0, reg_wr, reg_sel, start_req, stop_req, bit_req, bit_val, sda_pull;
    reg  [7:0] reg_wdata;
    reg  [6:0] addr_in;
    reg  [3:0] stretch;
    wire [7:0] reg_rdata;
    wire       busy, done, rx_bit, addr_match, scl_out, scl_oe, sda_out, sda_oe, scl_line, sda_line;
    integer    error_cnt = 0, compares = 0, i;
    reg [31:0] seed = 32'h8d4f;
    reg [45:0] e;
    always #4 ref_clk = ~ref_clk;
    i2rt_timing u_i2rt_timing (.ref_clk(ref_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_sel(reg_sel),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .start_req(start_req), .stop_req(stop_req),
        .bit_req(bit_req), .bit_val(bit_val), .busy(busy), .done(done), .rx_bit(rx_bit), .addr_in(addr_in),
        .addr_match(addr_match), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe));
    i2rt_bus_model u_i2rt_bus_model (.ref_clk(ref_clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .stretch(stretch),
        .sda_pull(sda_pull), .scl_line(scl_line), .sda_line(sda_line));
    function automatic [31:0] xs(input [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        xs = v ^ (v << 5);
    endfunction
    // Code, then divider, data hold, start hold, stop hold
    function automatic [45:0] tab(input [2:0] j);
        case (j)
            3'h0: tab = {6'h00, 10'd20, 10'd7, 10'd6, 10'd11};
            3'h1: tab = {6'h07, 10'd40, 10'd10, 10'd16, 10'd21};
            3'h2: tab = {6'h14, 10'd80, 10'd17, 10'd34, 10'd41};
            3'h3: tab = {6'h1f, 10'd240, 10'd33, 10'd118, 10'd121};
            default: tab = {6'h2f, 10'd960, 10'd129, 10'd478, 10'd481};
        endcase
    endfunction
    task finish_test;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp, input [31:0] tol);
        compares = compares + 1;
        if ((^got === 1'bx) || got + tol < exp || got > exp + tol) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input s, input [7:0] d);
        @(posedge ref_clk);
        {reg_sel, reg_wdata, reg_wr} <= {s, d, 1'b1};
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task req(input [2:0] v);
        @(posedge ref_clk);
        {bit_req, stop_req, start_req} <= v;
        @(posedge ref_clk);
        {bit_req, stop_req, start_req} <= 3'h0;
    endtask
    // Count cycles until a line enable or done reaches a level
    task wt(input integer w, input v, output integer c);
        c = 0;
        while (((w == 0) ? scl_oe : (w == 1) ? sda_oe : done) !== v && c < 20000) begin
            @(posedge ref_clk);
            #1;
            c = c + 1;
        end
    endtask
    task xfer(input [2:0] j, input [1:0] s, input [3:0] st, input pull);
        integer k, a, b, d;
        k = (s == 2'h1) ? 2 : (s == 2'h2) ? 4 : 1;
        e = tab(j);
        wr(1'b1, {s, e[45:40]});
        chk(reg_rdata, {s, e[45:40]}, 0);
        stretch <= st;
        req(3'h1);
        wt(1, 1'b1, a);
        chk(busy, 1, 0);
        wt(0, 1'b1, b);
        chk(a + b, k * e[19:10] + 1, 2);
        wt(2, 1'b1, d);
        req(3'h1);
        wt(2, 1'b1, d);
        chk(d + 2, k * (e[29:20] + e[39:31] + e[19:10]), 1);
        {sda_pull, bit_val} <= {pull, 1'b1};
        req(3'h4);
        wt(1, 1'b0, a);
        chk(a + 2, k * e[29:20], 1);
        wt(0, 1'b0, b);
        wt(0, 1'b1, d);
        chk(a + b + d + 2, k * e[39:30] + st, 2);
        wt(2, 1'b1, d);
        chk(rx_bit, !pull, 0);
        sda_pull <= 1'b0;
        req(3'h2);
        wt(1, 1'b1, a);
        wt(1, 1'b0, b);
        chk(b, k * e[9:0] + st, 4);
        wt(2, 1'b1, d);
        chk(busy, 0, 0);
    endtask
    initial begin
        {reg_wr, reg_sel, reg_wdata, start_req, stop_req, bit_req, bit_val, addr_in, stretch, sda_pull} = 0;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        chk(reg_rdata, 8'h00, 0);
        @(posedge ref_clk);
        reg_sel <= 1'b1;
        #1;
        chk(reg_rdata, 8'h00, 0);
        for (i = 0; i < 6; i = i + 1) begin
            seed = xs(seed);
            wr(1'b0, seed[7:0]);
            chk(reg_rdata, {seed[7:1], 1'b0}, 0);
            addr_in <= seed[7:1] ^ {6'h0, seed[8]};
            #1;
            chk(addr_match, !seed[8], 0);
        end
        xfer(3'h0, 2'h0, 4'h0, 1'b1);
        xfer(3'h3, 2'h3, 4'h0, 1'b0);
        xfer(3'h4, 2'h0, 4'h3, 1'b1);
        for (i = 0; i < 5; i = i + 1) begin
            seed = xs(seed);
            xfer(seed[2:0] % 5, seed[9:8], seed[12:10], seed[14]);
        end
        finish_test;
    end
    initial begin
        #720000;
        error_cnt = error_cnt + 1;
        finish_test;
    end
endmodule // i2rt_timing_tb
bind i2rt_timing i2rt_checker u_i2rt_checker (.ref_clk(ref_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .addr_in(addr_in), .addr_match(addr_match), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));
